// ---- design/ccr_consts.svh ----
// Constants of the codec channel register bank: command layout, offsets,
// reset values and write masks of reserved bits.
// Assumes inclusion by bare name from the command parser and the bank modules.
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

// Command byte layout
`define CCR_CMD_DIR_BIT 7
`define CCR_CMD_ADDR_MASK 8'h7f

// Register offsets (command byte with the direction bit cleared)
`define CCR_OFS_MODE 8'h05
`define CCR_OFS_GAIN_RING 8'h06
`define CCR_OFS_RAMP_METER 8'h07
`define CCR_OFS_METER_SRC 8'h08
`define CCR_OFS_METER_THR 8'h09
`define CCR_OFS_DEBOUNCE 8'h0a
`define CCR_OFS_SAMPLE_LO 8'h0b
`define CCR_OFS_SAMPLE_HI 8'h0c
`define CCR_OFS_TD_RTIME 8'h0d
`define CCR_OFS_TD_RBRK 8'h0e
`define CCR_OFS_TD_ETIME 8'h0f
`define CCR_OFS_TD_EBRK 8'h10
`define CCR_OFS_LINE_MASK 8'h11
`define CCR_OFS_IO_MASK 8'h12
`define CCR_OFS_IO_DIR 8'h13
`define CCR_OFS_EVT_SRC 8'h14
`define CCR_OFS_PLL 8'h20

// Reset values
`define CCR_RST_MODE 8'h80
`define CCR_RST_TD_RTIME 8'h13
`define CCR_RST_TD_RBRK 8'h19
`define CCR_RST_TD_ETIME 8'h40
`define CCR_RST_TD_EBRK 8'h64
`define CCR_RST_LINE_MASK 8'h1f
`define CCR_RST_IO_MASK 8'h0f
`define CCR_RST_EVT_SRC 8'h01
`define CCR_RST_ZERO 8'h00

// Implemented bits; reserved bits are cleared on write and read as zero
`define CCR_MSK_FULL 8'hff
`define CCR_MSK_GAIN_RING 8'h3f
`define CCR_MSK_RAMP_METER 8'hbf
`define CCR_MSK_METER_THR 8'he7
`define CCR_MSK_LINE_MASK 8'h1f
`define CCR_MSK_IO_MASK 8'h3f
`define CCR_MSK_PLL 8'h80

// Field positions
`define CCR_BIT_PLL_OFF 7
`define CCR_BIT_CH_PDOWN 7
`define CCR_BIT_METER_GAIN 6
`define CCR_BIT_METER_RECT 5
`define CCR_THR_MSB 2
`define CCR_IO_MASK_MSB 3

`endif

// ---- design/ccr_pkg.sv ----
// Types shared by the codec channel register bank modules.
// Assumes the constants header is on the include path.
package ccr_pkg;
  typedef logic [7:0] ccr_byte_t;
  typedef logic [15:0][7:0] ccr_bank_t;
  typedef enum logic [0:0] {
    CCR_WAIT_CMD = 1'b0,
    CCR_WAIT_DATA = 1'b1
  } ccr_parse_state_t;
endpackage

// ---- design/ccr_cmd_parser.sv ----
// Command/data byte sequencer for one host port of the register bank.
// Assumes one byte per byte_valid cycle, synchronous to clk.
`include "ccr_consts.svh"

module ccr_cmd_parser (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Byte stream from the host port
  input wire logic byte_valid,
  input wire ccr_pkg::ccr_byte_t byte_in,
  // Decoded access
  output logic rd_pulse,
  output logic wr_pulse,
  output ccr_pkg::ccr_byte_t addr,
  output ccr_pkg::ccr_byte_t wdata
);
  import ccr_pkg::*;

  ccr_parse_state_t state;
  ccr_parse_state_t next_state;
  logic cmd_is_write;
  logic take_cmd;
  logic take_data;

  // Direction from the top bit of the command byte
  assign cmd_is_write = byte_in[`CCR_CMD_DIR_BIT];
  assign take_cmd = byte_valid && (state == CCR_WAIT_CMD);
  assign take_data = byte_valid && (state == CCR_WAIT_DATA);

  // Next state: a write waits for its data byte, a read completes at once
  always_comb begin
    next_state = state;
    case (state)
      CCR_WAIT_CMD: begin
        if (take_cmd && cmd_is_write) begin
          next_state = CCR_WAIT_DATA;
        end
      end
      CCR_WAIT_DATA: begin
        if (take_data) begin
          next_state = CCR_WAIT_CMD;
        end
      end
      default: next_state = CCR_WAIT_CMD;
    endcase
  end

  // State and decoded access flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= CCR_WAIT_CMD;
      rd_pulse <= 1'b0;
      wr_pulse <= 1'b0;
      addr <= `CCR_RST_ZERO;
      wdata <= `CCR_RST_ZERO;
    end else begin
      state <= next_state;
      rd_pulse <= take_cmd && !cmd_is_write;
      wr_pulse <= take_data;
      if (take_cmd) begin
        addr <= byte_in & `CCR_CMD_ADDR_MASK;
      end
      if (take_data) begin
        wdata <= byte_in;
      end
    end
  end
endmodule

// ---- design/ccr_bank.sv ----
// Per-channel and global register bank of a four-channel voice codec.
// Assumes both host ports deliver bytes synchronous to clk and that the
// channel-enable mask comes from the channel selection logic outside.
//
// Summary of operation
// - The top bit of a command byte picks the direction: zero reads, one writes.
// - Hosts write zeros into reserved bits, and reserved bits carry no meaning when read.
// - Every register answers the same way over the microprocessor port and the serial port.
// - The PLL register reads at 20H and writes at A0H, with only its top bit working.
// - A zero PLL power-off bit keeps the PLL running and is the reset value; one stops it.
// - The operating-mode register reads at 05H, writes at 85H and resets to 80H.
// - The IO interrupt mask register reads at 12H, writes at 92H and resets to 0FH.
// - The event source and feed register is read-only at 14H and resets to 01H.
// - The meter threshold and gain register reads at 09H, writes at 89H and resets to 00H.
`include "ccr_consts.svh"

module ccr_bank #(
  parameter int NCH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Port select: low uses the microprocessor port, high the serial port
  input wire logic port_is_serial,
  // Microprocessor port byte stream
  input wire logic microprocessor_port_valid,
  input wire ccr_pkg::ccr_byte_t microprocessor_port_byte,
  // Serial circuit interface byte stream
  input wire logic serial_port_valid,
  input wire ccr_pkg::ccr_byte_t serial_port_byte,
  // Channels addressed by local commands
  input wire logic [NCH-1:0] chan_enable,
  // Read answer
  output logic rd_valid,
  output ccr_pkg::ccr_byte_t rd_data,
  // Status captured from the channel functions
  input wire logic [NCH-1:0] sample_load,
  input wire logic [NCH-1:0][15:0] voice_sample_in,
  input wire logic [NCH-1:0] event_load,
  input wire ccr_pkg::ccr_byte_t event_status_in [NCH],
  // Configuration towards the channel functions
  output ccr_pkg::ccr_bank_t local_cfg [NCH],
  output logic [NCH-1:0] chan_power_down,
  output logic [NCH-1:0][2:0] meter_threshold_field,
  output logic [NCH-1:0] meter_rectifier_switch,
  output logic [NCH-1:0] meter_gain_factor,
  output logic [NCH-1:0][3:0] io_int_mask,
  // Global PLL control
  output logic pll_power_off_bit
);
  import ccr_pkg::*;

  localparam logic [3:0] IDX_SAMPLE_LO = 4'h6;
  localparam logic [3:0] IDX_SAMPLE_HI = 4'h7;
  localparam logic [3:0] IDX_EVT_SRC = 4'hf;

  // Refuse channel counts the channel select cannot address
  generate
    if (NCH < 1 || NCH > 4) begin : g_bad_nch
      $error("ccr_bank: NCH must lie between 1 and 4");
    end
  endgenerate

  // True when an offset falls in the local register window
  function automatic logic is_local(input ccr_byte_t a);
    is_local = (a >= `CCR_OFS_MODE) && (a <= `CCR_OFS_EVT_SRC);
  endfunction

  // Index of a local register inside the bank
  function automatic logic [3:0] local_index(input ccr_byte_t a);
    ccr_byte_t d;
    d = a - `CCR_OFS_MODE;
    local_index = d[3:0];
  endfunction

  // Reset value of each local register
  function automatic ccr_byte_t reset_of(input logic [3:0] i);
    ccr_byte_t v;
    v = `CCR_RST_ZERO;
    case ({4'h0, i} + `CCR_OFS_MODE)
      `CCR_OFS_MODE: v = `CCR_RST_MODE;
      `CCR_OFS_TD_RTIME: v = `CCR_RST_TD_RTIME;
      `CCR_OFS_TD_RBRK: v = `CCR_RST_TD_RBRK;
      `CCR_OFS_TD_ETIME: v = `CCR_RST_TD_ETIME;
      `CCR_OFS_TD_EBRK: v = `CCR_RST_TD_EBRK;
      `CCR_OFS_LINE_MASK: v = `CCR_RST_LINE_MASK;
      `CCR_OFS_IO_MASK: v = `CCR_RST_IO_MASK;
      `CCR_OFS_EVT_SRC: v = `CCR_RST_EVT_SRC;
      `CCR_OFS_METER_THR: v = `CCR_RST_ZERO;
      default: v = `CCR_RST_ZERO;
    endcase
    reset_of = v;
  endfunction

  // Implemented bits of each local register
  function automatic ccr_byte_t mask_of(input logic [3:0] i);
    ccr_byte_t m;
    m = `CCR_MSK_FULL;
    case ({4'h0, i} + `CCR_OFS_MODE)
      `CCR_OFS_GAIN_RING: m = `CCR_MSK_GAIN_RING;
      `CCR_OFS_RAMP_METER: m = `CCR_MSK_RAMP_METER;
      `CCR_OFS_METER_THR: m = `CCR_MSK_METER_THR;
      `CCR_OFS_LINE_MASK: m = `CCR_MSK_LINE_MASK;
      `CCR_OFS_IO_MASK: m = `CCR_MSK_IO_MASK;
      default: m = `CCR_MSK_FULL;
    endcase
    mask_of = m;
  endfunction

  // Registers written only by the channel functions, never by a host
  function automatic logic is_read_only(input logic [3:0] i);
    is_read_only = (i == IDX_SAMPLE_LO) || (i == IDX_SAMPLE_HI) || (i == IDX_EVT_SRC);
  endfunction

  // Lowest enabled channel answers local reads
  function automatic logic [1:0] first_chan(input logic [NCH-1:0] en);
    logic [1:0] c;
    c = 2'h0;
    for (int k = NCH - 1; k >= 0; k--) begin
      if (en[k]) begin
        c = k[1:0];
      end
    end
    first_chan = c;
  endfunction

  // One sequencer per host port; both feed the same decode below
  logic mpi_rd;
  logic mpi_wr;
  ccr_byte_t mpi_addr;
  ccr_byte_t mpi_wdata;
  logic ser_rd;
  logic ser_wr;
  ccr_byte_t ser_addr;
  ccr_byte_t ser_wdata;

  ccr_cmd_parser u_mpi_parser (
    .clk(clk),
    .nrst(nrst),
    .byte_valid(microprocessor_port_valid && !port_is_serial),
    .byte_in(microprocessor_port_byte),
    .rd_pulse(mpi_rd),
    .wr_pulse(mpi_wr),
    .addr(mpi_addr),
    .wdata(mpi_wdata)
  );

  ccr_cmd_parser u_ser_parser (
    .clk(clk),
    .nrst(nrst),
    .byte_valid(serial_port_valid && port_is_serial),
    .byte_in(serial_port_byte),
    .rd_pulse(ser_rd),
    .wr_pulse(ser_wr),
    .addr(ser_addr),
    .wdata(ser_wdata)
  );

  // Port merge; a switch of port_is_serial mid-command leaves that command pending in its port's sequencer until reselected
  logic acc_rd;
  logic acc_wr;
  ccr_byte_t acc_addr;
  ccr_byte_t acc_wdata;
  assign acc_rd = port_is_serial ? ser_rd : mpi_rd;
  assign acc_wr = port_is_serial ? ser_wr : mpi_wr;
  assign acc_addr = port_is_serial ? ser_addr : mpi_addr;
  assign acc_wdata = port_is_serial ? ser_wdata : mpi_wdata;

  // Address decode
  logic hit_local;
  logic hit_pll;
  logic [3:0] acc_idx;
  logic local_wr;
  logic pll_wr;
  assign hit_local = is_local(acc_addr);
  assign hit_pll = (acc_addr == `CCR_OFS_PLL);
  assign acc_idx = local_index(acc_addr);
  assign local_wr = acc_wr && hit_local && !is_read_only(acc_idx);
  assign pll_wr = acc_wr && hit_pll;

  // Reserved bits dropped before storage so they read as zero
  ccr_byte_t wr_clean;
  assign wr_clean = acc_wdata & mask_of(acc_idx);

  // Local bank storage
  ccr_bank_t bank [NCH];

  // Each channel: host writes, status captures, reset defaults
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        for (int i = 0; i < 16; i++) begin
          bank[c][i] <= reset_of(i[3:0]);
        end
      end else begin
        if (local_wr && chan_enable[c]) begin
          bank[c][acc_idx] <= wr_clean;
        end
        if (sample_load[c]) begin
          bank[c][IDX_SAMPLE_LO] <= voice_sample_in[c][7:0];
          bank[c][IDX_SAMPLE_HI] <= voice_sample_in[c][15:8];
        end
        if (event_load[c]) begin
          bank[c][IDX_EVT_SRC] <= event_status_in[c];
        end
      end
    end

    // Field taps towards the channel functions
    assign local_cfg[c] = bank[c];
    assign chan_power_down[c] =
      bank[c][local_index(`CCR_OFS_MODE)][`CCR_BIT_CH_PDOWN];
    assign meter_threshold_field[c] =
      bank[c][local_index(`CCR_OFS_METER_THR)][`CCR_THR_MSB:0];
    assign meter_rectifier_switch[c] =
      bank[c][local_index(`CCR_OFS_METER_THR)][`CCR_BIT_METER_RECT];
    assign meter_gain_factor[c] =
      bank[c][local_index(`CCR_OFS_METER_THR)][`CCR_BIT_METER_GAIN];
    assign io_int_mask[c] =
      bank[c][local_index(`CCR_OFS_IO_MASK)][`CCR_IO_MASK_MSB:0];
  end

  // Global PLL control; zero after reset keeps the PLL running
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pll_power_off_bit <= 1'b0;
    end else if (pll_wr) begin
      pll_power_off_bit <= acc_wdata[`CCR_BIT_PLL_OFF];
    end
  end

  // Read selection; unmapped offsets, and local reads under an empty channel mask, answer zero
  logic [1:0] rd_chan;
  logic any_chan;
  ccr_byte_t local_value;
  ccr_byte_t pll_value;
  ccr_byte_t read_value;
  assign rd_chan = first_chan(chan_enable);
  assign any_chan = |chan_enable;
  assign local_value = (any_chan && hit_local) ? bank[rd_chan][acc_idx] : `CCR_RST_ZERO;
  assign pll_value = {pll_power_off_bit, 7'h00} & `CCR_MSK_PLL;
  assign read_value = hit_pll ? pll_value : local_value;

  // Read answer registered one cycle after the decoded read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
      rd_data <= `CCR_RST_ZERO;
    end else begin
      rd_valid <= acc_rd;
      if (acc_rd) begin
        rd_data <= read_value;
      end
    end
  end
endmodule

// ---- testbench/ccr_bank_checker.sv ----
// Assertion checker for the codec register bank.
// Assumes one clock domain and the active-low asynchronous reset.
module ccr_bank_checker #(
  parameter int NCH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Host byte streams
  input wire logic port_is_serial,
  input wire logic microprocessor_port_valid,
  input wire ccr_pkg::ccr_byte_t microprocessor_port_byte,
  input wire logic serial_port_valid,
  input wire ccr_pkg::ccr_byte_t serial_port_byte,
  input wire logic [NCH-1:0] chan_enable,
  // Answers and configuration
  input wire logic rd_valid,
  input wire logic [NCH-1:0] chan_power_down,
  input wire logic [NCH-1:0][2:0] meter_threshold_field,
  input wire logic [NCH-1:0] meter_rectifier_switch,
  input wire logic [NCH-1:0] meter_gain_factor,
  input wire logic [NCH-1:0][3:0] io_int_mask,
  input wire logic pll_power_off_bit
);
  import ccr_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Live port byte and a shadow of the command/data sequence
  wire logic sel_v = port_is_serial ? serial_port_valid : microprocessor_port_valid;
  wire ccr_byte_t sel_b = port_is_serial ? serial_port_byte : microprocessor_port_byte;
  wire logic sel_top = sel_b[7];
  wire logic [3:0] sel_lo = sel_b[3:0];
  wire logic [4:0] sel_meter = {sel_b[6:5], sel_b[2:0]};
  logic want_data;
  ccr_byte_t last_cmd;
  wire logic rd_cmd = sel_v && !want_data && !sel_top;
  wire logic wdat = sel_v && want_data;
  wire logic pll_wr = wdat && last_cmd == 8'ha0;
  // Shadow parser, so data bytes never pose as commands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      want_data <= 1'b0;
      last_cmd <= 8'h00;
    end else if (sel_v) begin
      want_data <= !want_data && sel_top;
      last_cmd <= want_data ? last_cmd : sel_b;
    end
  end
  read_answer_a: assert property (rd_cmd |-> ##2 rd_valid)
    else $error("read command not answered");
  answer_cause_a: assert property (rd_valid |-> $past(rd_cmd, 2))
    else $error("read answer without read command");
  pll_write_a: assert property (pll_wr |-> ##2 pll_power_off_bit == $past(sel_top, 2))
    else $error("pll bit not written");
  pll_hold_a: assert property ($changed(pll_power_off_bit) |-> $past(pll_wr, 2))
    else $error("pll bit changed without write");
  mode_write_a: assert property (wdat && last_cmd == 8'h85 && chan_enable[0] |->
    ##2 chan_power_down[0] == $past(sel_top, 2)) else $error("power down bit not written");
  mask_write_a: assert property (wdat && last_cmd == 8'h92 && chan_enable[0] |->
    ##2 io_int_mask[0] == $past(sel_lo, 2)) else $error("io mask not written");
  meter_write_a: assert property (wdat && last_cmd == 8'h89 && chan_enable[0] |->
    ##2 {meter_gain_factor[0], meter_rectifier_switch[0], meter_threshold_field[0]}
    == $past(sel_meter, 2)) else $error("meter fields not written");
  reset_value_a: assert property ($rose(nrst) |-> !pll_power_off_bit &&
    chan_power_down[0] && io_int_mask[0] == 4'hf && !rd_valid) else $error("bad reset state");
endmodule

// ---- testbench/ccr_host_model.sv ----
// Host processor model issuing command and data bytes.
// Assumes calls from one process; released lines toggle every byte time.
module ccr_host_model (
  // Clock and live port choice
  input wire logic clk,
  input wire logic port_is_serial,
  // Byte streams towards the bank
  output logic mp_valid,
  output ccr_pkg::ccr_byte_t mp_byte,
  output logic sp_valid,
  output ccr_pkg::ccr_byte_t sp_byte
);
  import ccr_pkg::*;
  initial begin
    mp_valid = 1'b0;
    sp_valid = 1'b0;
    mp_byte = 8'h00;
    sp_byte = 8'h00;
  end
  // One byte on the live port; the other port's valid stays low and its old byte is inverted
  task automatic put(input ccr_byte_t b);
    @(negedge clk);
    mp_valid = !port_is_serial;
    sp_valid = port_is_serial;
    mp_byte = port_is_serial ? ~mp_byte : b;
    sp_byte = port_is_serial ? b : ~sp_byte;
  endtask
  // Stale data must never look valid
  task automatic idle();
    @(negedge clk);
    mp_valid = 1'b0;
    sp_valid = 1'b0;
    mp_byte = ~mp_byte;
    sp_byte = ~sp_byte;
  endtask
  task automatic rd(input ccr_byte_t a);
    put({1'b0, a[6:0]});
  endtask
  task automatic wr(input ccr_byte_t a, input ccr_byte_t d);
    put({1'b1, a[6:0]});
    put(d);
  endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the register bank, driven by the host model.
// Assumes design, checker and host model compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ccr_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic port_is_serial = 1'b0;
  logic [3:0] chan_enable = 4'hf;
  logic [3:0] sample_load = 4'h0;
  logic [3:0] event_load = 4'h0;
  logic [3:0][15:0] voice_sample_in = '0;
  ccr_byte_t event_status_in [4] = '{default: 8'h00};
  logic mp_valid, sp_valid, rd_valid, pll_power_off_bit;
  logic [3:0] chan_power_down, meter_rectifier_switch, meter_gain_factor;
  logic [3:0][2:0] meter_threshold_field;
  logic [3:0][3:0] io_int_mask;
  ccr_byte_t mp_byte, sp_byte, rd_data, a, d, v;
  ccr_bank_t local_cfg [4];
  ccr_byte_t img [64];
  ccr_byte_t regs [18] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d,
    8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20, 8'h3f};
  int n_errors = 0;
  int check_count = 0;
  int seed = 32'ha3e6d9c9;
  always #5 clk = ~clk;
  ccr_host_model host (.clk, .port_is_serial, .mp_valid, .mp_byte, .sp_valid, .sp_byte);
  ccr_bank #(.NCH(4)) dut (.clk, .nrst, .port_is_serial,
    .microprocessor_port_valid(mp_valid), .microprocessor_port_byte(mp_byte),
    .serial_port_valid(sp_valid), .serial_port_byte(sp_byte), .chan_enable, .rd_valid,
    .rd_data, .sample_load, .voice_sample_in, .event_load, .event_status_in, .local_cfg,
    .chan_power_down, .meter_threshold_field, .meter_rectifier_switch, .meter_gain_factor,
    .io_int_mask, .pll_power_off_bit);
  // Reset values
  function automatic ccr_byte_t dflt(input ccr_byte_t r);
    case (r)
      8'h05: return 8'h80;
      8'h0d: return 8'h13;
      8'h0e: return 8'h19;
      8'h0f: return 8'h40;
      8'h10: return 8'h64;
      8'h11: return 8'h1f;
      8'h12: return 8'h0f;
      8'h14: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction
  // Writable bits; read-only and unmapped places take nothing
  function automatic ccr_byte_t wmask(input ccr_byte_t r);
    case (r)
      8'h06, 8'h12: return 8'h3f;
      8'h07: return 8'hbf;
      8'h09: return 8'he7;
      8'h11: return 8'h1f;
      8'h20: return 8'h80;
      8'h05, 8'h08, 8'h0a, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h13: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input string what, input ccr_byte_t exp, input ccr_byte_t got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Read one offset; the answer pulse is awaited under a bound
  task automatic rd_chk(input ccr_byte_t r, input ccr_byte_t exp);
    host.rd(r);
    host.idle();
    for (int i = 0; i < 4 && rd_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("rd_valid", 8'h01, {7'h0, rd_valid});
    chk("rd_data", exp, rd_data);
  endtask
  task automatic do_reset();
    @(negedge clk);
    nrst = 1'b0;
    chan_enable = 4'hf;
    repeat (4) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    foreach (img[i]) img[i] = dflt(8'(i));
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    foreach (regs[k]) rd_chk(regs[k], img[regs[k]]);
    // Status capture through the load strobes
    v = 8'($random(seed));
    // Strobes raised off the edge so one rising edge takes them
    @(negedge clk);
    voice_sample_in[0] = {v, ~v};
    event_status_in[0] = v ^ 8'h5a;
    sample_load = 4'h1;
    event_load = 4'h1;
    @(negedge clk);
    sample_load = 4'h0;
    event_load = 4'h0;
    img[8'h0b] = ~v;
    img[8'h0c] = v;
    img[8'h14] = v ^ 8'h5a;
    rd_chk(8'h0b, img[8'h0b]);
    rd_chk(8'h0c, img[8'h0c]);
    rd_chk(8'h14, img[8'h14]);
    host.wr(8'h20, 8'h80);
    img[8'h20] = 8'h80;
    rd_chk(8'h20, 8'h80);
    // Random writes, each read back at once on a random port
    for (int n = 0; n < 60; n++) begin
      @(negedge clk);
      a = regs[$unsigned($random(seed)) % 18];
      d = 8'($random(seed));
      port_is_serial = 1'($random(seed));
      if (wmask(a) !== 8'h00) d = d & wmask(a);
      host.wr(a, d);
      img[a] = (img[a] & ~wmask(a)) | (d & wmask(a));
      rd_chk(a, img[a]);
      chk("pll", {7'h0, img[8'h20][7]}, {7'h0, pll_power_off_bit});
      // Bank image: channel 0 for every local, channel 3 for host-written ones
      if (a >= 8'h05 && a <= 8'h14) begin
        chk("local_cfg0", img[a], local_cfg[0][4'(a - 8'h05)]);
      end
      if (a >= 8'h05 && a <= 8'h14 && wmask(a) !== 8'h00) begin
        chk("local_cfg3", img[a], local_cfg[3][4'(a - 8'h05)]);
      end
    end
    // Local reads with no channel enabled answer zero
    @(negedge clk);
    chan_enable = 4'h0;
    rd_chk(8'h05, 8'h00);
    do_reset();
    foreach (regs[k]) rd_chk(regs[k], img[regs[k]]);
    close_out();
  end
  // Watchdog far beyond the run's needs
  initial begin
    #60000;
    n_errors++;
    close_out();
  end
endmodule
bind ccr_bank ccr_bank_checker #(.NCH(NCH)) chk_i (.clk, .nrst, .port_is_serial,
  .microprocessor_port_valid, .microprocessor_port_byte, .serial_port_valid,
  .serial_port_byte, .chan_enable, .rd_valid, .chan_power_down, .meter_threshold_field,
  .meter_rectifier_switch, .meter_gain_factor, .io_int_mask, .pll_power_off_bit);
